/* pkg/ffp_pkg.sv */
// Function
// [RULE1] Four non-overlapping phases from the system clock form one instruction cycle.
// [RULE2] Program counter steps at fetch phase start; next instruction fetched then.
// [RULE3] Decode and execution happen in the three decode/execute phases.
// [RULE4] Fetch of one instruction overlaps execution of the previous one.
// [RULE5] Standard instructions take one cycle, extended instructions take two.
// [RULE6] Counter-changing instructions take one extra cycle: target, then branch.
// [RULE7] Eight-bit arithmetic unit does all operations through the accumulator.
// [RULE8] Taken conditional skip discards the prefetch and inserts one dummy cycle.
// [RULE9] Write to counter low byte jumps within page, inserting one dummy cycle.
// [RULE10] Reset leaves prefetch empty; first fetch is from the reset vector.
package ffp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int FFP_PC_W = 13;
    localparam int FFP_INSTR_W = 16;
    localparam int FFP_DATA_W = 8;
    localparam int FFP_PAGE_W = 8;
    localparam int FFP_NUM_PHASES = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Phase positions within the one-hot phase vector
    localparam int FFP_PH_FETCH = 0;
    localparam int FFP_PH_LAST = 3;
    localparam logic [3:0] FFP_PHASE_RST = 4'h1;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [12:0] FFP_RESET_VECTOR = 13'h0000;
    localparam logic [15:0] FFP_NOP_WORD = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction word fields
    localparam int FFP_CLASS_MSB = 15;
    localparam int FFP_CLASS_LSB = 13;
    localparam int FFP_OP_MSB = 12;
    localparam int FFP_OP_LSB = 9;
    localparam int FFP_IMM_MSB = 7;
    localparam int FFP_IMM_LSB = 0;

    // Instruction classes
    localparam logic [2:0] FFP_CL_STD = 3'h0;
    localparam logic [2:0] FFP_CL_EXT = 3'h1;
    localparam logic [2:0] FFP_CL_JMP = 3'h2;
    localparam logic [2:0] FFP_CL_CALL = 3'h3;
    localparam logic [2:0] FFP_CL_SKIP = 3'h4;
    localparam logic [2:0] FFP_CL_PCLW = 3'h5;

    // Arithmetic unit operations
    localparam logic [3:0] FFP_OP_ADD = 4'h0;
    localparam logic [3:0] FFP_OP_SUB = 4'h1;
    localparam logic [3:0] FFP_OP_AND = 4'h2;
    localparam logic [3:0] FFP_OP_OR = 4'h3;
    localparam logic [3:0] FFP_OP_XOR = 4'h4;
    localparam logic [3:0] FFP_OP_CPL = 4'h5;
    localparam logic [3:0] FFP_OP_RRC = 4'h6;
    localparam logic [3:0] FFP_OP_RLC = 4'h7;
    localparam logic [3:0] FFP_OP_INC = 4'h8;
    localparam logic [3:0] FFP_OP_DEC = 4'h9;
    localparam logic [3:0] FFP_OP_MOV = 4'ha;

    ////////////////////////////////////////////////////////////////////////////////
    // Execute slot state
    typedef enum logic [1:0] {
        FFP_SLOT_DUMMY,
        FFP_SLOT_EXEC,
        FFP_SLOT_EXT2
    } ffp_slot_t;

endpackage

/* logic/ffp_phase_gen.sv */
`timescale 1ns/1ns
module ffp_phase_gen
    import ffp_pkg::*;
(
    input wire logic ref_clk_i, // System clock
    input wire logic rst_n_i, // Async reset, active low
    output logic [3:0] phase_o // One-hot phase, bit 0 is fetch
);

    ////////////////////////////////////////////////////////////////////////////////
    // Rotating one-hot ring, exactly one phase active per clock
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_o <= FFP_PHASE_RST;
        end else begin
            phase_o <= {phase_o[2:0], phase_o[3]}; // [RULE1]
        end
    end

endmodule

/* logic/ffp_pipeline.sv */
`timescale 1ns/1ns
module ffp_pipeline
    import ffp_pkg::*;
#(
    parameter int PC_W = FFP_PC_W
)
(
    input wire logic ref_clk_i, // 250 MHz system clock
    input wire logic rst_n_i, // Async reset, active low
    output logic [PC_W-1:0] prog_addr_o, // Program memory address
    output logic prog_rd_o, // Fetch strobe, high in fetch phase
    input wire logic [15:0] prog_data_i, // Program memory word
    output logic [3:0] phase_o, // One-hot phase
    output logic [7:0] acc_o, // Accumulator
    output logic carry_o, // Carry flag
    output logic zero_o, // Zero flag
    output logic retire_o, // Pulse when an instruction completes
    output logic dummy_o, // High during a dummy cycle
    output logic call_o, // Pulse when a call branches
    output logic [PC_W-1:0] return_addr_o // Address following the last call
);

    ////////////////////////////////////////////////////////////////////////////////
    // Arithmetic unit: carry in bit 8, result in bits 7:0
    function automatic logic [8:0] alu(input logic [3:0] op, input logic [7:0] a,
                                       input logic [7:0] b, input logic c);
        logic [8:0] r;
        r = {c, a};
        unique case (op)
            FFP_OP_ADD: r = {1'b0, a} + {1'b0, b};
            FFP_OP_SUB: r = {1'b0, a} - {1'b0, b};
            FFP_OP_AND: r = {c, a & b};
            FFP_OP_OR: r = {c, a | b};
            FFP_OP_XOR: r = {c, a ^ b};
            FFP_OP_CPL: r = {c, ~a};
            FFP_OP_RRC: r = {a[0], c, a[7:1]};
            FFP_OP_RLC: r = {a[7], a[6:0], c};
            FFP_OP_INC: r = {1'b0, a} + 9'h001;
            FFP_OP_DEC: r = {1'b0, a} - 9'h001;
            FFP_OP_MOV: r = {c, b};
            default: r = {c, a};
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State
    logic [PC_W-1:0] pc;
    logic [15:0] fetched;
    logic [15:0] ir;
    ffp_slot_t slot;
    logic [7:0] acc;
    logic carry;
    logic zero;

    logic [3:0] phase;
    logic fetch_end;
    logic cycle_end;

    ////////////////////////////////////////////////////////////////////////////////
    // Phase generator
    ffp_phase_gen u_phase (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .phase_o(phase)
    );

    // Fetch phase ends / instruction cycle ends
    assign fetch_end = phase[FFP_PH_FETCH];
    assign cycle_end = phase[FFP_PH_LAST]; // [RULE1]

    ////////////////////////////////////////////////////////////////////////////////
    // Decode of the instruction in the execute slot
    logic [2:0] ir_class;
    logic [3:0] ir_op;
    logic [7:0] ir_imm;
    logic [PC_W-1:0] ir_target;
    logic [8:0] alu_res;

    assign ir_class = ir[FFP_CLASS_MSB:FFP_CLASS_LSB];
    assign ir_op = ir[FFP_OP_MSB:FFP_OP_LSB];
    assign ir_imm = ir[FFP_IMM_MSB:FFP_IMM_LSB];
    assign ir_target = ir[PC_W-1:0];
    assign alu_res = alu(ir_op, acc, ir_imm, carry); // [RULE7]

    logic is_std;
    logic is_ext;
    logic is_jmp;
    logic is_call;
    logic is_skip;
    logic is_pclw;

    assign is_std = (ir_class == FFP_CL_STD);
    assign is_ext = (ir_class == FFP_CL_EXT);
    assign is_jmp = (ir_class == FFP_CL_JMP);
    assign is_call = (ir_class == FFP_CL_CALL);
    assign is_skip = (ir_class == FFP_CL_SKIP);
    assign is_pclw = (ir_class == FFP_CL_PCLW);

    ////////////////////////////////////////////////////////////////////////////////
    // Completion and redirect decisions, taken at the end of the last phase
    logic ext_hold;
    logic commit;
    logic take_branch;
    logic take_skip;
    logic take_pclw;
    logic flush;
    logic acc_write;

    // First half of an extended instruction holds the pipe one cycle
    assign ext_hold = cycle_end && (slot == FFP_SLOT_EXEC) && is_ext; // [RULE5]
    // Execution completes over the decode/execute phases, committed at the last
    assign commit = cycle_end && (((slot == FFP_SLOT_EXEC) && !is_ext) ||
                                  (slot == FFP_SLOT_EXT2)); // [RULE3] [RULE5]
    assign take_branch = commit && (is_jmp || is_call); // [RULE6]
    assign take_skip = commit && is_skip && (alu_res[7:0] == 8'h00); // [RULE8]
    assign take_pclw = commit && is_pclw; // [RULE9]
    assign flush = take_branch || take_skip || take_pclw;
    assign acc_write = commit && (is_std || is_ext || is_skip); // [RULE7]

    ////////////////////////////////////////////////////////////////////////////////
    // Next program counter
    logic [PC_W-1:0] next_pc;
    logic [PC_W-1:0] pc_step;
    logic [PC_W-1:0] pc_page;

    assign pc_step = pc + 1'b1;
    // Page bits kept, low byte replaced by the computed value
    assign pc_page = {pc[PC_W-1:FFP_PAGE_W], alu_res[7:0]}; // [RULE9]

    always_comb begin
        next_pc = pc;
        if (!cycle_end || ext_hold) begin
            next_pc = pc;
        end else if (take_branch) begin
            next_pc = ir_target; // [RULE6]
        end else if (take_pclw) begin
            next_pc = pc_page; // [RULE9]
        end else begin
            next_pc = pc_step; // [RULE2]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next execute slot state
    ffp_slot_t next_slot;

    always_comb begin
        next_slot = slot;
        if (cycle_end) begin
            if (flush) begin
                next_slot = FFP_SLOT_DUMMY; // [RULE6] [RULE8] [RULE9]
            end else if (ext_hold) begin
                next_slot = FFP_SLOT_EXT2; // [RULE5]
            end else begin
                next_slot = FFP_SLOT_EXEC; // [RULE4]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Program counter, stepped as the fetch phase begins
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc <= FFP_RESET_VECTOR[PC_W-1:0]; // [RULE10]
        end else begin
            pc <= next_pc; // [RULE2]
        end
    end

    // Fetch latch, captured at the end of the fetch phase
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fetched <= FFP_NOP_WORD;
        end else if (fetch_end) begin
            fetched <= prog_data_i; // [RULE2]
        end
    end

    // Prefetched word moves to execute while the next one is fetched
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ir <= FFP_NOP_WORD;
        end else if (cycle_end && !ext_hold) begin
            ir <= fetched; // [RULE4]
        end
    end

    // Slot state; reset leaves the prefetch empty
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slot <= FFP_SLOT_DUMMY; // [RULE10]
        end else begin
            slot <= next_slot;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Accumulator and flags
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc <= 8'h00;
            carry <= 1'b0;
            zero <= 1'b0;
        end else if (acc_write) begin
            acc <= alu_res[7:0]; // [RULE7]
            carry <= alu_res[8];
            zero <= (alu_res[7:0] == 8'h00);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prog_addr_o <= FFP_RESET_VECTOR[PC_W-1:0];
            prog_rd_o <= 1'b1;
            phase_o <= FFP_PHASE_RST;
            dummy_o <= 1'b1;
        end else begin
            prog_addr_o <= next_pc;
            prog_rd_o <= cycle_end; // [RULE2]
            phase_o <= {phase[2:0], phase[3]};
            dummy_o <= (next_slot == FFP_SLOT_DUMMY); // [RULE8] [RULE9]
        end
    end

    // Completion and call reporting
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_o <= 8'h00;
            carry_o <= 1'b0;
            zero_o <= 1'b0;
            retire_o <= 1'b0;
            call_o <= 1'b0;
            return_addr_o <= '0;
        end else begin
            acc_o <= acc_write ? alu_res[7:0] : acc;
            carry_o <= acc_write ? alu_res[8] : carry;
            zero_o <= acc_write ? (alu_res[7:0] == 8'h00) : zero;
            retire_o <= commit;
            call_o <= take_branch && is_call; // [RULE6]
            if (take_branch && is_call) begin
                return_addr_o <= pc;
            end
        end
    end

endmodule

/* tb/ffp_prog_mem.sv */
`timescale 1ns/1ns
module ffp_prog_mem (
    input wire logic [12:0] addr_i, // Fetch address
    input wire logic rd_i, // Fetch strobe
    output logic [15:0] data_o // Program word
);
    logic [15:0] mem [0:63];
    logic [15:0] word;
    // Small program store; unused space reads as all ones, and every word is inverted while the fetch strobe is low
    assign word = (addr_i < 13'h0040) ? mem[addr_i[5:0]] : 16'hffff;
    assign data_o = rd_i ? word : ~word;
endmodule

/* tb/ffp_chk.sv */
`timescale 1ns/1ns
module ffp_chk #(
    parameter int PC_W = 13
)
(
    input wire logic ref_clk_i, // Clock
    input wire logic rst_n_i, // Reset, active low
    input wire logic [PC_W-1:0] prog_addr_o, // Address
    input wire logic prog_rd_o, // Fetch strobe
    input wire logic [3:0] phase_o, // Phase
    input wire logic [7:0] acc_o, // Accumulator
    input wire logic retire_o, // Retire pulse
    input wire logic dummy_o, // Dummy cycle
    input wire logic call_o // Call pulse
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////////////
    // Phase, fetch, retire, call, accumulator, dummy and reset checks
    chk_phase_hot: assert property ($onehot(phase_o))
        else $error("phase not one-hot");
    chk_phase_rot: assert property ($past(rst_n_i) |-> phase_o == {$past(phase_o[2:0]), $past(phase_o[3])})
        else $error("phase did not rotate");
    chk_fetch_strobe: assert property (prog_rd_o == phase_o[0])
        else $error("fetch strobe outside fetch phase");
    chk_addr_hold: assert property (!phase_o[3] |=> $stable(prog_addr_o))
        else $error("address moved inside a cycle");
    chk_retire_phase: assert property (retire_o |-> phase_o[0])
        else $error("retire outside fetch phase");
    chk_retire_gap: assert property (retire_o |=> !retire_o [*3])
        else $error("two retires in one cycle");
    chk_call_retire: assert property (call_o |-> retire_o)
        else $error("call without retire");
    chk_acc_commit: assert property ($changed(acc_o) |-> retire_o)
        else $error("accumulator changed without retire");
    chk_dummy_none: assert property (retire_o |-> !$past(dummy_o))
        else $error("retire after dummy cycle");
    chk_dummy_hold: assert property (!phase_o[3] |=> $stable(dummy_o))
        else $error("dummy flag moved inside a cycle");
    chk_reset_empty: assert property (!$past(rst_n_i) |-> dummy_o && prog_addr_o == '0)
        else $error("prefetch not empty after reset");
endmodule
bind ffp_pipeline ffp_chk #(.PC_W(PC_W)) u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .prog_addr_o(prog_addr_o), .prog_rd_o(prog_rd_o), .phase_o(phase_o), .acc_o(acc_o),
    .retire_o(retire_o), .dummy_o(dummy_o), .call_o(call_o));

/* tb/tb_ffp_pipeline.sv */
`timescale 1ns/1ns
module tb_ffp_pipeline;
    import ffp_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [12:0] prog_addr, ret_addr;
    logic [15:0] prog_data;
    logic [3:0] phase;
    logic [7:0] acc;
    logic prog_rd, carry, zero, retire, dummy, call;
    logic [17:0] exp_q[$]; // {carry, time check, cycle index, acc}
    logic [17:0] e;
    integer seed = 32'h3bd4;
    int n_mismatch = 0;
    int cmp_count = 0;
    int clk_cnt = 0;
    int base = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, design and program store
    always #2 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) clk_cnt <= clk_cnt + 1;
    ffp_pipeline #(.PC_W(13)) DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .prog_addr_o(prog_addr), .prog_rd_o(prog_rd), .prog_data_i(prog_data),
        .phase_o(phase), .acc_o(acc), .carry_o(carry), .zero_o(zero), .retire_o(retire),
        .dummy_o(dummy), .call_o(call), .return_addr_o(ret_addr));
    ffp_prog_mem u_mem (.addr_i(prog_addr), .rd_i(prog_rd), .data_o(prog_data));
    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [15:0] w(input logic [2:0] c, input logic [3:0] o,
        input logic [7:0] i);
        return {c, o, 1'b0, i};
    endfunction
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Loads a program under reset, notes expected retires, then runs it
    task automatic run_prog();
        logic [7:0] r0, r1, r2, r3;
        logic [8:0] s9;
        int k;
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        // Let reset clear any retire pulse before new notes are queued
        @(posedge ref_clk_i);
        exp_q.delete();
        r0 = 8'($random(seed));
        r1 = 8'($random(seed));
        r2 = 8'($random(seed));
        r3 = 8'($random(seed));
        r3[7] = 1'b0;
        s9 = {1'b0, r0} + {1'b0, r1};
        for (k = 0; k < 64; k++) u_mem.mem[k] = w(FFP_CL_STD, FFP_OP_MOV, 8'hff);
        u_mem.mem[0] = w(FFP_CL_STD, FFP_OP_MOV, r0);
        u_mem.mem[1] = w(FFP_CL_STD, FFP_OP_ADD, r1);
        u_mem.mem[2] = {FFP_CL_JMP, 13'h0008};
        u_mem.mem[8] = w(FFP_CL_SKIP, FFP_OP_MOV, 8'h00);
        u_mem.mem[10] = {FFP_CL_CALL, 13'h0010};
        u_mem.mem[16] = w(FFP_CL_STD, FFP_OP_MOV, r2);
        u_mem.mem[17] = w(FFP_CL_PCLW, FFP_OP_MOV, 8'h20);
        u_mem.mem[32] = w(FFP_CL_EXT, FFP_OP_MOV, r3);
        u_mem.mem[33] = w(FFP_CL_SKIP, FFP_OP_ADD, 8'h01);
        u_mem.mem[34] = w(FFP_CL_STD, FFP_OP_MOV, 8'h5a);
        u_mem.mem[35] = w(FFP_CL_STD, FFP_OP_SUB, 8'h5b);
        u_mem.mem[36] = w(FFP_CL_STD, FFP_OP_RLC, 8'h00);
        u_mem.mem[37] = w(FFP_CL_STD, FFP_OP_XOR, 8'h0f);
        u_mem.mem[38] = w(FFP_CL_STD, FFP_OP_RRC, 8'h00);
        u_mem.mem[39] = w(FFP_CL_STD, FFP_OP_AND, 8'h3c);
        u_mem.mem[40] = w(FFP_CL_STD, FFP_OP_OR, 8'h41);
        u_mem.mem[41] = w(FFP_CL_STD, FFP_OP_CPL, 8'h00);
        u_mem.mem[42] = w(FFP_CL_STD, FFP_OP_INC, 8'h00);
        u_mem.mem[43] = w(FFP_CL_STD, FFP_OP_DEC, 8'h00);
        u_mem.mem[44] = w(3'h6, FFP_OP_INC, 8'h00);
        u_mem.mem[45] = w(FFP_CL_STD, 4'hb, 8'h00);
        u_mem.mem[46] = {FFP_CL_JMP, 13'h002e};
        exp_q = '{{1'b0, 1'b1, 8'd0, r0}, {s9[8], 1'b1, 8'd1, s9[7:0]},
            {s9[8], 1'b1, 8'd2, s9[7:0]}, {s9[8], 1'b1, 8'd4, 8'h00},
            {s9[8], 1'b1, 8'd6, 8'h00}, {s9[8], 1'b1, 8'd8, r2},
            {s9[8], 1'b1, 8'd9, r2}, {s9[8], 1'b1, 8'd12, r3},
            {1'b0, 1'b1, 8'd13, 8'(r3 + 8'h01)}, {1'b0, 1'b1, 8'd14, 8'h5a},
            {1'b1, 1'b1, 8'd15, 8'hff}, {1'b1, 1'b1, 8'd16, 8'hff},
            {1'b1, 1'b1, 8'd17, 8'hf0}, {1'b0, 1'b1, 8'd18, 8'hf8},
            {1'b0, 1'b1, 8'd19, 8'h38}, {1'b0, 1'b1, 8'd20, 8'h79},
            {1'b0, 1'b1, 8'd21, 8'h86}, {1'b0, 1'b1, 8'd22, 8'h87},
            {1'b0, 1'b1, 8'd23, 8'h86}, {1'b0, 1'b1, 8'd24, 8'h86},
            {1'b0, 1'b1, 8'd25, 8'h86}};
        repeat (10) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        for (k = 0; k < 400 && exp_q.size() > 0; k++) @(posedge ref_clk_i);
        if (exp_q.size() > 0) begin
            n_mismatch++;
            $display("[ERR] retire count expected 0 left seen %0d left", exp_q.size());
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Retire watcher: oldest note against each completed instruction
    always @(posedge ref_clk_i) begin
        if (call === 1'b1) check("return address", 16'h000b, {3'h0, ret_addr});
        if (retire === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e[15:8] == 8'd0) base = clk_cnt;
            check("accumulator", {8'h00, e[7:0]}, {8'h00, acc});
            check("carry", {15'h0, e[17]}, {15'h0, carry});
            check("zero", {15'h0, e[7:0] == 8'h00}, {15'h0, zero});
            if (e[16]) check("retire time", {6'h0, e[15:8], 2'b00}, 16'(clk_cnt - base));
        end
    end
    // Two runs, the second reset cutting into the first run's idle loop
    initial begin
        run_prog();
        run_prog();
        end_of_test();
    end
endmodule
